// file: inc/fct_pkg.sv
// constants, register map and timing for the fixed-cycle interrupt timer
// Functional notes
// - while running, count down once per source tick; event on step one to zero.
// - run enable falling makes counter and stored preset invalid.
// - preset register read during countdown returns live count, not latched.
// - run enable is read/write; zero stops the timer, one starts it.
// - each event sets the sticky event flag; read returns one once detected.
// - writing zero clears the flag; counting continues while run enable is one.
// - level mode: clearing the flag releases the interrupt pin to high-Z.
// - level mode: after clear, next one-to-zero step sets flag, pin low again.
// - writing one to the event flag has no effect on it.
// - with output enable one, each event drives the interrupt pin low.
// - output enable zero keeps pin released; clearing it releases a low pin.
// - level mode: enabling output while flag set drives pin low at once.
// - mode bit zero is level mode, one is repeated pulsed mode.
// - interval select 00=4096 Hz, 01=64 Hz, 10=seconds tick, 11=minute tick.
// - repeated mode: pin held low for auto-release time, then released.
// - after each event reload counter from preset, keep counting while enabled.
package fct_pkg;
    localparam int CLOCK_HZ = 40_000_000;
    localparam int BASE_TICK_HZ = 4096;
    localparam int DIV_64HZ = 64;
    localparam int DIV_1HZ = 4096;
    localparam int DIV_MIN = 60;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL2 = 8'h01;
    localparam logic [7:0] IDX_TCTRL = 8'h0e;
    localparam logic [7:0] IDX_TPRESET = 8'h0f;
    localparam logic [7:0] IDX_TSTAT = 8'h10;

    // control 2 fields
    localparam int CTRL2_TIE_BIT = 0;
    localparam int CTRL2_TF_BIT = 2;
    localparam int CTRL2_MODE_BIT = 4;
    // timer control fields
    localparam int TCTRL_TD_LO = 0;
    localparam int TCTRL_TD_HI = 1;
    localparam int TCTRL_TE_BIT = 7;
    // status fields
    localparam int TSTAT_PIN_BIT = 0;
    localparam int TSTAT_RUN_BIT = 1;
    localparam int TSTAT_HOLD_BIT = 2;

    localparam logic [7:0] PRESET_RST = 8'h00;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        FCT_SRC_4096HZ = 2'b00,
        FCT_SRC_64HZ = 2'b01,
        FCT_SRC_SEC = 2'b10,
        FCT_SRC_MIN = 2'b11
    } fct_src_t;

    // auto-release times, nanoseconds, and derived cycle counts (rounded down)
    localparam int RTN_122US_NS = 122_000;
    localparam int RTN_244US_NS = 244_000;
    localparam int RTN_7813US_NS = 7_813_000;
    localparam int RTN_15625US_NS = 15_625_000;
    localparam int RTN_122US_CYC = RTN_122US_NS * (CLOCK_HZ / 1_000_000) / 1000;
    localparam int RTN_244US_CYC = RTN_244US_NS * (CLOCK_HZ / 1_000_000) / 1000;
    localparam int RTN_7813US_CYC = RTN_7813US_NS * (CLOCK_HZ / 1_000_000) / 1000;
    localparam int RTN_15625US_CYC = RTN_15625US_NS * (CLOCK_HZ / 1_000_000) / 1000;
    localparam int RTN_CNT_W = 20;
endpackage : fct_pkg

// file: hdl/fct_timer.sv
// fixed-cycle down-count interrupt timer with avalon-mm register slave
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module fct_timer
    import fct_pkg::*;
#(
    parameter int CLK_HZ = CLOCK_HZ,
    parameter int TICK_HZ = BASE_TICK_HZ,
    parameter int RTN_122US = RTN_122US_CYC,
    parameter int RTN_244US = RTN_244US_CYC,
    parameter int RTN_7813US = RTN_7813US_CYC,
    parameter int RTN_15625US = RTN_15625US_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // open-drain interrupt pin, active low
    input wire logic irq_n_i,
    output logic irq_n_o,
    output logic irq_n_oe
);

    // reset release
    logic rst_meta_q;
    logic rst_sync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // register state
    logic timer_run_enable_q;
    logic timer_event_flag_q;
    logic timer_irq_output_enable_q;
    logic irq_pulse_or_hold_select_q;
    logic countdown_interval_select_hi_q;
    logic countdown_interval_select_lo_q;
    logic [7:0] preset_q;
    logic [7:0] count_q;
    logic preset_valid_q;

    // bus decode
    logic req;
    logic ack;
    logic wr_ack;
    logic lane0;
    logic hit_ctrl2;
    logic hit_tctrl;
    logic hit_tpreset;
    logic hit_tstat;
    logic [7:0] wbyte;

    assign req = avs_read | avs_write;
    assign ack = req & ~avs_waitrequest;
    assign wr_ack = ack & avs_write;
    // registers sit on byte lane 0 only
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign hit_ctrl2 = (avs_address == {IDX_CTRL2[5:0], 2'b00});
    assign hit_tctrl = (avs_address == {IDX_TCTRL[5:0], 2'b00});
    assign hit_tpreset = (avs_address == {IDX_TPRESET[5:0], 2'b00});
    assign hit_tstat = (avs_address == {IDX_TSTAT[5:0], 2'b00});

    logic wr_ctrl2;
    logic wr_tctrl;
    logic wr_tpreset;

    assign wr_ctrl2 = wr_ack & lane0 & hit_ctrl2;
    assign wr_tctrl = wr_ack & lane0 & hit_tctrl;
    assign wr_tpreset = wr_ack & lane0 & hit_tpreset;

    // source tick generation: fractional base divider then integer dividers
    logic [31:0] acc_q;
    logic tick_base_q;
    logic [5:0] div64_q;
    logic [11:0] div1hz_q;
    logic [5:0] divmin_q;
    logic tick_64_q;
    logic tick_sec_q;
    logic tick_min_q;
    logic [31:0] acc_sum;

    assign acc_sum = acc_q + 32'(TICK_HZ);

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            acc_q <= 32'h0000_0000;
            tick_base_q <= 1'b0;
        end else if (acc_sum >= 32'(CLK_HZ)) begin
            acc_q <= acc_sum - 32'(CLK_HZ);
            tick_base_q <= 1'b1;
        end else begin
            acc_q <= acc_sum;
            tick_base_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div64_q <= 6'h00;
            tick_64_q <= 1'b0;
        end else begin
            tick_64_q <= 1'b0;
            if (tick_base_q) begin
                if (div64_q == 6'(DIV_64HZ - 1)) begin
                    div64_q <= 6'h00;
                    tick_64_q <= 1'b1;
                end else begin
                    div64_q <= div64_q + 6'h01;
                end
            end
        end
    end

    // seconds tick free-runs, so the first step after a start may come early
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div1hz_q <= 12'h000;
            tick_sec_q <= 1'b0;
        end else begin
            tick_sec_q <= 1'b0;
            if (tick_base_q) begin
                if (div1hz_q == 12'(DIV_1HZ - 1)) begin
                    div1hz_q <= 12'h000;
                    tick_sec_q <= 1'b1;
                end else begin
                    div1hz_q <= div1hz_q + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            divmin_q <= 6'h00;
            tick_min_q <= 1'b0;
        end else begin
            tick_min_q <= 1'b0;
            if (tick_sec_q) begin
                if (divmin_q == 6'(DIV_MIN - 1)) begin
                    divmin_q <= 6'h00;
                    tick_min_q <= 1'b1;
                end else begin
                    divmin_q <= divmin_q + 6'h01;
                end
            end
        end
    end

    // source clock select
    fct_src_t src_sel;
    logic src_tick;

    assign src_sel = fct_src_t'({countdown_interval_select_hi_q, countdown_interval_select_lo_q});

    always_comb begin
        case (src_sel)
            FCT_SRC_4096HZ: src_tick = tick_base_q;
            FCT_SRC_64HZ: src_tick = tick_64_q;
            FCT_SRC_SEC: src_tick = tick_sec_q;
            FCT_SRC_MIN: src_tick = tick_min_q;
            default: src_tick = 1'b0;
        endcase
    end

    // control bits
    logic run_fall;

    // stop clears both values, so every restart needs a fresh preset
    assign run_fall = wr_tctrl & timer_run_enable_q & ~wbyte[TCTRL_TE_BIT];

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_run_enable_q <= 1'b0;
            countdown_interval_select_hi_q <= 1'b0;
            countdown_interval_select_lo_q <= 1'b0;
        end else if (wr_tctrl) begin
            timer_run_enable_q <= wbyte[TCTRL_TE_BIT];
            countdown_interval_select_hi_q <= wbyte[TCTRL_TD_HI];
            countdown_interval_select_lo_q <= wbyte[TCTRL_TD_LO];
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_irq_output_enable_q <= 1'b0;
            irq_pulse_or_hold_select_q <= 1'b0;
        end else if (wr_ctrl2) begin
            timer_irq_output_enable_q <= wbyte[CTRL2_TIE_BIT];
            irq_pulse_or_hold_select_q <= wbyte[CTRL2_MODE_BIT];
        end
    end

    // down counter
    logic running;
    logic timer_event;

    assign running = timer_run_enable_q & preset_valid_q & (count_q != 8'h00);
    assign timer_event = running & src_tick & (count_q == 8'h01);

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            preset_q <= PRESET_RST;
            count_q <= PRESET_RST;
            preset_valid_q <= 1'b0;
        end else if (run_fall) begin
            // stop: both values no longer usable
            preset_q <= PRESET_RST;
            count_q <= PRESET_RST;
            preset_valid_q <= 1'b0;
        end else if (wr_tpreset && !timer_run_enable_q) begin
            // zero preset leaves the timer idle
            preset_q <= wbyte;
            count_q <= wbyte;
            preset_valid_q <= (wbyte != 8'h00);
        end else if (timer_event) begin
            count_q <= preset_q;
        end else if (running && src_tick) begin
            count_q <= count_q - 8'h01;
        end
    end

    // event flag: set wins over a simultaneous clear
    logic flag_clear;

    assign flag_clear = wr_ctrl2 & ~wbyte[CTRL2_TF_BIT];

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_event_flag_q <= 1'b0;
        end else if (timer_event) begin
            timer_event_flag_q <= 1'b1;
        end else if (flag_clear) begin
            timer_event_flag_q <= 1'b0;
        end
    end

    // repeated-mode auto-release hold
    logic [RTN_CNT_W-1:0] rtn_q;
    logic [RTN_CNT_W-1:0] rtn_load;
    logic hold_start;
    logic hold_active;

    // hold runs only for pulses; level mode keeps the pin through the flag
    assign hold_start = timer_event & timer_irq_output_enable_q & irq_pulse_or_hold_select_q;
    assign hold_active = (rtn_q != '0);

    always_comb begin
        case (src_sel)
            FCT_SRC_4096HZ: rtn_load = (preset_q == 8'h01) ? RTN_CNT_W'(RTN_122US)
                                                           : RTN_CNT_W'(RTN_244US);
            FCT_SRC_64HZ: rtn_load = (preset_q == 8'h01) ? RTN_CNT_W'(RTN_7813US)
                                                         : RTN_CNT_W'(RTN_15625US);
            FCT_SRC_SEC: rtn_load = RTN_CNT_W'(RTN_15625US);
            FCT_SRC_MIN: rtn_load = RTN_CNT_W'(RTN_15625US);
            default: rtn_load = RTN_CNT_W'(RTN_15625US);
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rtn_q <= '0;
        end else if (hold_start) begin
            rtn_q <= rtn_load;
        end else if (!timer_irq_output_enable_q) begin
            // disabling output ends a pulse for good
            rtn_q <= '0;
        end else if (hold_active) begin
            rtn_q <= rtn_q - RTN_CNT_W'(1);
        end
    end

    // interrupt pin drive
    logic pin_low_d;

    always_comb begin
        if (irq_pulse_or_hold_select_q) begin
            // flag clear does not cut a pulse short
            pin_low_d = timer_irq_output_enable_q & hold_active;
        end else begin
            pin_low_d = timer_irq_output_enable_q & timer_event_flag_q;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_n_oe <= 1'b0;
            irq_n_o <= 1'b0;
        end else begin
            irq_n_oe <= pin_low_d;
            irq_n_o <= 1'b0;
        end
    end

    // register read mux
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = RDATA_UNMAPPED;
        if (hit_ctrl2) begin
            rdata_d[CTRL2_TIE_BIT] = timer_irq_output_enable_q;
            rdata_d[CTRL2_TF_BIT] = timer_event_flag_q;
            rdata_d[CTRL2_MODE_BIT] = irq_pulse_or_hold_select_q;
        end else if (hit_tctrl) begin
            rdata_d[TCTRL_TE_BIT] = timer_run_enable_q;
            rdata_d[TCTRL_TD_HI] = countdown_interval_select_hi_q;
            rdata_d[TCTRL_TD_LO] = countdown_interval_select_lo_q;
        end else if (hit_tpreset) begin
            rdata_d[7:0] = count_q;
        end else if (hit_tstat) begin
            rdata_d[TSTAT_PIN_BIT] = irq_n_i;
            rdata_d[TSTAT_RUN_BIT] = running;
            rdata_d[TSTAT_HOLD_BIT] = hold_active;
        end
    end

    // one wait cycle, then a one-cycle acknowledge
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_waitrequest <= 1'b1;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // read data captured with the answer and held until the next one
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_readdata <= RDATA_UNMAPPED;
        end else if (req && avs_waitrequest) begin
            avs_readdata <= rdata_d;
        end
    end

endmodule : fct_timer

// file: verification/fct_timer_checker.sv
// port assertions for the fixed-cycle timer
`timescale 1ns/10ps
module fct_timer_checker
    import fct_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // interrupt pin
    input wire logic irq_n_i,
    input wire logic irq_n_o,
    input wire logic irq_n_oe
);
    logic req, c2_wr, mapped;
    logic rst_q1, rst_ok;
    // design logic leaves reset two edges after rst_n rises
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_ok <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_ok <= rst_q1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_ok);
    assign req = avs_read || avs_write;
    assign c2_wr = avs_write && !avs_waitrequest && avs_address == 8'h04 && avs_byteenable[0];
    assign mapped = avs_address inside {8'h04, 8'h38, 8'h3c, 8'h40};
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !mapped
        |-> avs_readdata == RDATA_UNMAPPED)
        else $error("unmapped read not zero");
    a_od_low: assert property (irq_n_oe |-> !irq_n_o)
        else $error("pin driven high");
    a_reset_idle: assert property (disable iff (1'b0) !rst_n ##1 !rst_n
        |-> avs_waitrequest && !irq_n_oe)
        else $error("outputs active in reset");
    a_flag_release: assert property (c2_wr && !avs_writedata[2] && !avs_writedata[4]
        |-> ##2 !irq_n_oe)
        else $error("pin held after flag clear");
    a_oe_release: assert property (c2_wr && !avs_writedata[0] |-> ##2 !irq_n_oe)
        else $error("pin held after output disable");
    c_ctrl_write: cover property (c2_wr);
    c_pin_low: cover property ($rose(irq_n_oe));
    c_unmapped: cover property (avs_read && !avs_waitrequest && !mapped);
endmodule : fct_timer_checker

bind fct_timer fct_timer_checker i_chk (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_n_i(irq_n_i), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));

// file: verification/fct_host_pin.sv
// host side of the interrupt pin: pull-up wire and low-time meter
`timescale 1ns/10ps
module fct_host_pin (
    // clock
    input wire logic clock,
    // pin from device
    input wire logic irq_n_o,
    input wire logic irq_n_oe,
    // wire level and length of last low phase
    output logic irq_wire,
    output int low_len
);
    int cnt = 0;
    // released pin reads high through the pull-up
    assign irq_wire = irq_n_oe ? irq_n_o : 1'b1;
    always_ff @(posedge clock) begin
        if (irq_wire === 1'b0) begin
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            low_len <= cnt;
            cnt <= 0;
        end
    end
endmodule : fct_host_pin

// file: verification/fct_timer_tb_top.sv
// self-checking bench for the fixed-cycle timer
`timescale 1ns/10ps
module fct_timer_tb_top;
    import fct_pkg::*;
    localparam logic [7:0] A_C2 = {IDX_CTRL2[5:0], 2'b00};
    localparam logic [7:0] A_TC = {IDX_TCTRL[5:0], 2'b00};
    localparam logic [7:0] A_PR = {IDX_TPRESET[5:0], 2'b00};
    localparam logic [7:0] A_ST = {IDX_TSTAT[5:0], 2'b00};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq_n_i, irq_n_o, irq_n_oe;
    logic [31:0] seed = 32'h1e;
    logic [7:0] q, q1, p;
    logic [1:0] sel;
    int low_len;
    int num_errors = 0;
    int total_checks = 0;

    fct_timer #(.CLK_HZ(8192), .RTN_122US(5), .RTN_244US(10), .RTN_7813US(20),
        .RTN_15625US(40)) i_dut (.clock(clock), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq_n_i(irq_n_i), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
    fct_host_pin i_host (.clock(clock), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
        .irq_wire(irq_n_i), .low_len(low_len));

    initial begin
        forever #12.5 clock = ~clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs

    // pulse length in cycles for the scaled release times
    function automatic int rtn_len(input logic [1:0] s, input logic [7:0] n);
        if (s == 2'b00) begin
            return (n == 8'h01) ? 5 : 10;
        end
        return (s == 2'b01 && n == 8'h01) ? 20 : 40;
    endfunction : rtn_len

    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chkn(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            num_errors++;
            $display("Error at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask : chkn

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] be);
        int n = 0;
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus

    task automatic wait_pin(input logic lvl, input int lim);
        int n = 0;
        while (irq_n_i !== lvl && n < lim) begin
            @(posedge clock);
            n++;
        end
        chkn(int'(irq_n_i === lvl), 1);
    endtask : wait_pin

    initial begin
        #(25 * 40000);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        bus(0, A_PR, 8'h00, 4'hf);
        chk8(q, PRESET_RST);
        bus(0, 8'h08, 8'h00, 4'hf);
        chk8(q, 8'h00);
        for (int k = 0; k < 4; k++) begin
            bus(1, A_TC, 8'(k), 4'hf);
            bus(0, A_TC, 8'h00, 4'hf);
            chk8(q, 8'(k));
        end
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            p = (seed[7:0] == 8'h00) ? 8'h01 : seed[7:0];
            bus(1, A_PR, p, 4'hf);
            bus(1, A_PR, ~p, 4'h0);
            bus(0, A_PR, 8'h00, 4'hf);
            chk8(q, p);
        end
        // level mode: hold, clear, re-trigger, disable and re-enable
        seed = xs(seed);
        p = 8'd20 + {3'h0, seed[4:0]};
        bus(1, A_PR, p, 4'hf);
        bus(1, A_C2, 8'h01, 4'hf);
        bus(1, A_TC, 8'h80, 4'hf);
        bus(0, A_PR, 8'h00, 4'hf);
        q1 = q;
        bus(0, A_PR, 8'h00, 4'hf);
        chkn(int'(q < q1 && q1 <= p && q != 8'h00), 1);
        wait_pin(1'b0, 2 * p + 20);
        bus(0, A_ST, 8'h00, 4'hf);
        chk8(q, 8'h02);
        bus(1, A_C2, 8'h05, 4'hf);
        bus(0, A_C2, 8'h00, 4'hf);
        chk8(q, 8'h05);
        bus(1, A_C2, 8'h01, 4'hf);
        repeat (2) @(posedge clock);
        chk8({7'h0, irq_n_i}, 8'h01);
        wait_pin(1'b0, 2 * p + 10);
        bus(1, A_C2, 8'h04, 4'hf);
        repeat (2) @(posedge clock);
        chk8({7'h0, irq_n_i}, 8'h01);
        bus(0, A_C2, 8'h00, 4'hf);
        chk8(q, 8'h04);
        bus(1, A_C2, 8'h05, 4'hf);
        repeat (2) @(posedge clock);
        chk8({7'h0, irq_n_i}, 8'h00);
        bus(1, A_TC, 8'h00, 4'hf);
        bus(0, A_PR, 8'h00, 4'hf);
        chk8(q, 8'h00);
        bus(0, A_C2, 8'h00, 4'hf);
        chk8(q, 8'h05);
        bus(1, A_C2, 8'h00, 4'hf);
        // repeated mode: pulse length by source and preset, two pulses each
        for (int k = 0; k < 4; k++) begin
            sel = (k == 0) ? 2'b00 : ((k == 3) ? 2'b10 : 2'b01);
            p = (k == 0) ? 8'h08 : ((k == 3) ? 8'h01 : 8'(k));
            bus(1, A_PR, p, 4'hf);
            bus(1, A_C2, 8'h11, 4'hf);
            bus(1, A_TC, {6'h20, sel}, 4'hf);
            repeat (2) begin
                wait_pin(1'b0, (sel == 2'b10) ? 8400 : 140 * p);
                bus(0, A_ST, 8'h00, 4'hf);
                chk8(q, 8'h06);
                wait_pin(1'b1, 60);
                @(posedge clock);
                chkn(low_len, rtn_len(sel, p));
            end
            bus(1, A_TC, 8'h00, 4'hf);
            bus(1, A_C2, 8'h00, 4'hf);
        end
        end_sim();
    end
endmodule : fct_timer_tb_top
